// file: rtl/hrap_host_port.sv
`timescale 1ns/1ps
`include "hrap_defs.svh"
// Contract
// - Address style: write on data strobe rising.
// - Address style: drive read data while strobe low.
// - Chip select low drives ready low.
// - Eight-bit data bus, released unless reading.
// - Separate style: drive data while read low.
// - Ready high at completion, hi-z when deselected.
// - Acknowledge low at completion, high otherwise.
module hrap_host_port
   import hrap_pkg::*;
(
   input  wire logic                    clk_sys,                // System clock, 200 MHz.
   input  wire logic                    reset_n,                // Asynchronous reset, active low.
   input  wire logic                    mode_strap,             // High selects separate strobes.
   input  wire logic                    chip_select_n,          // Chip select pin.
   input  wire logic                    address_latch_strobe_n, // Address strobe pin.
   input  wire logic                    write_or_data_strobe_n, // Write or data strobe pin.
   input  wire logic                    read_or_direction,      // Read strobe or direction pin.
   input  wire logic [`HRAP_ADDR_W-1:0] host_addr,              // Register index pins.
   input  wire logic [`HRAP_DATA_W-1:0] host_data_in,           // Data bus as seen on the pins.
   output logic      [`HRAP_DATA_W-1:0] host_data_out,          // Read data driven to the pins.
   output logic                         host_data_oe,           // Data bus output enable.
   output logic                         ack_out,                // Ready or acknowledge level.
   output logic                         ack_oe,                 // Ready or acknowledge enable.
   output logic      [`HRAP_ADDR_W-1:0] reg_addr,               // Index to the register file.
   output logic      [`HRAP_DATA_W-1:0] reg_wdata,              // Write data to the register file.
   output logic                         reg_wr,                 // One-cycle write pulse.
   output logic                         reg_rd,                 // One-cycle read pulse.
   input  wire logic [`HRAP_DATA_W-1:0] reg_rdata               // Register file read data.
);

   // =======================================================================
   // Input synchroniser
   // =======================================================================
   logic [`HRAP_SYNC_W-1:0] sync1_reg;   // First stage, read only by the second stage.
   logic [`HRAP_SYNC_W-1:0] sync2_reg;   // Second stage, safe for logic.
   logic                    strap1_reg;  // Strap first stage.
   logic                    strap2_reg;  // Strap second stage.
   wire  [`HRAP_SYNC_W-1:0] pins_raw;    // Pin bundle before synchronising.

   assign pins_raw = {host_data_in, host_addr, read_or_direction,
                      write_or_data_strobe_n, address_latch_strobe_n, chip_select_n};

   // All host pins are asynchronous to clk_sys; every one passes two stages.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sync1_reg  <= `HRAP_SYNC_RST;
         sync2_reg  <= `HRAP_SYNC_RST;
         strap1_reg <= 1'b0;
         strap2_reg <= 1'b0;
      end else begin
         sync1_reg  <= pins_raw;
         sync2_reg  <= sync1_reg;
         strap1_reg <= mode_strap;
         strap2_reg <= strap1_reg;
      end
   end

   // Named views of the synchronised pins.
   wire                    cs_s   = sync2_reg[`HRAP_POS_CS];
   wire                    astb_s = sync2_reg[`HRAP_POS_ASTB];
   wire                    wsd_s  = sync2_reg[`HRAP_POS_WSD];
   wire                    rdrw_s = sync2_reg[`HRAP_POS_RDRW];
   wire [`HRAP_ADDR_W-1:0] addr_s = sync2_reg[`HRAP_POS_ADDR +: `HRAP_ADDR_W];
   wire [`HRAP_DATA_W-1:0] data_s = sync2_reg[`HRAP_POS_DATA +: `HRAP_DATA_W];

   // =======================================================================
   // Mode strap capture
   // =======================================================================
   logic [1:0]    start_cnt_reg; // Counts edges until the strap sync is settled.
   logic          started_reg;   // Mode has been captured; accesses may run.
   hrap_mode_type mode_reg;      // Captured strobe style.

   // The strap is caught once after release, so a strap that wiggles later
   // cannot flip the protocol in the middle of an access.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         start_cnt_reg <= 2'h0;
         started_reg   <= 1'b0;
         mode_reg      <= HRAP_MODE_ADDR_STROBE;
      end else if (!started_reg) begin
         start_cnt_reg <= start_cnt_reg + 2'h1;
         if (start_cnt_reg == `HRAP_START_CNT) begin
            started_reg <= 1'b1;
            mode_reg    <= strap2_reg ? HRAP_MODE_SEP_STROBE : HRAP_MODE_ADDR_STROBE;
         end
      end
   end

   // =======================================================================
   // Access decode
   // =======================================================================
   // Select term of either style: chip select or address strobe low.
   function automatic logic sel_of(input logic sep, input logic cs_n, input logic astb_n);
      sel_of = sep ? ~cs_n : ~astb_n;
   endfunction : sel_of

   hrap_state_type state_reg;   // Sequencer state.
   hrap_state_type state_next;  // Sequencer next state.
   logic           done_reg;    // Current access has completed.
   logic           wr_arm_reg;  // A write strobe is low; waiting for its rising edge.

   wire sep     = (mode_reg == HRAP_MODE_SEP_STROBE);
   wire sel_act = started_reg & sel_of(sep, cs_s, astb_s);
   // Separate style reads on read strobe low; address style on data strobe
   // low with direction high.
   wire rd_req  = sel_act & (sep ? ~rdrw_s : (~wsd_s & rdrw_s));
   // Write strobe low; address style also needs direction low.
   wire wr_low  = sel_act & ~wsd_s & (sep | ~rdrw_s);
   // Rising edge of the strobe while still selected commits the write.
   wire wr_commit = wr_arm_reg & wsd_s & sel_act;
   wire idle    = (state_reg == HRAP_ST_IDLE);
   wire rd_start = idle & rd_req;

   // Sequencer: a read costs one cycle of register lookup before driving.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         HRAP_ST_IDLE: begin
            if (rd_req) begin
               state_next = HRAP_ST_READ;
            end
         end
         HRAP_ST_READ: begin
            state_next = HRAP_ST_DONE;
         end
         HRAP_ST_DONE: begin
            // Hold the data until the read strobe (or select) goes away.
            if (!rd_req) begin
               state_next = HRAP_ST_IDLE;
            end
         end
         default: begin
            state_next = HRAP_ST_IDLE;
         end
      endcase
   end

   // Completion flag: set at commit or read data ready, cleared on deselect
   // or the start of a fresh access.
   wire done_next = !sel_act ? 1'b0 :
                    ((state_reg == HRAP_ST_READ) | wr_commit) ? 1'b1 :
                    (idle & (rd_req | wr_low) & !wr_arm_reg) ? 1'b0 : done_reg;
   wire wr_arm_next = (!sel_act | wr_commit) ? 1'b0 :
                      (idle & wr_low & !rd_req) ? 1'b1 : wr_arm_reg;

   // Pin drivers of the next cycle.
   wire data_oe_next  = (state_next == HRAP_ST_DONE) & sel_act;
   wire ack_out_next  = sep ? done_reg : ~done_reg;
   wire ack_oe_next   = started_reg & (sep ? ~cs_s : 1'b1);

   // =======================================================================
   // State and output registers
   // =======================================================================
   // Sequencer and handshake flags.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg  <= HRAP_ST_IDLE;
         done_reg   <= 1'b0;
         wr_arm_reg <= 1'b0;
      end else begin
         state_reg  <= state_next;
         done_reg   <= done_next;
         wr_arm_reg <= wr_arm_next;
      end
   end

   // Register file side: index and data follow the pins while a write strobe
   // is low (a read takes them once, at its start), so the value at the rising edge is what gets written.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         reg_addr  <= `HRAP_ADDR_RST;
         reg_wdata <= `HRAP_DATA_RST;
         reg_wr    <= 1'b0;
         reg_rd    <= 1'b0;
      end else begin
         if (rd_start | (idle & wr_low)) begin
            reg_addr  <= addr_s;
            reg_wdata <= data_s;
         end
         reg_wr <= wr_commit;
         reg_rd <= rd_start;
      end
   end

   // Pin drivers; the data bus is released whenever no read is held.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         host_data_out <= `HRAP_DATA_RST;
         host_data_oe  <= `HRAP_OE_RST;
         ack_out       <= `HRAP_ACK_RST;
         ack_oe        <= `HRAP_OE_RST;
      end else begin
         if (state_reg == HRAP_ST_READ) begin
            host_data_out <= reg_rdata;
         end
         host_data_oe <= data_oe_next;
         ack_out      <= ack_out_next;
         ack_oe       <= ack_oe_next;
      end
   end

   // =======================================================================
   // Assertions
   // =======================================================================
   default clocking hrap_cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   data_release_a: assert property (host_data_oe |-> state_reg == HRAP_ST_DONE)
      else $error("Data bus driven outside a held read.");
   data_drop_a: assert property ((state_reg == HRAP_ST_DONE && !rd_req) |=> !host_data_oe)
      else $error("Data bus not released after read strobe.");
   sep_read_a: assert property ((sep && rd_start) |-> ##2 (host_data_oe || !sel_act))
      else $error("Separate-style read data not driven.");
   addr_read_a: assert property ((!sep && rd_start) |-> ##2 (host_data_oe || !rd_req))
      else $error("Address-style read data not driven.");
   sep_write_a: assert property ((sep && wr_arm_reg && wsd_s && !cs_s) |=> reg_wr)
      else $error("Separate-style write not committed.");
   addr_write_a: assert property ((!sep && wr_arm_reg && wsd_s && !astb_s) |=> reg_wr)
      else $error("Address-style write not committed.");
   ready_drive_a: assert property ((sep && started_reg && !cs_s) |=> ack_oe)
      else $error("Ready not driven with chip select low.");
   ready_float_a: assert property ((sep && cs_s) |=> !ack_oe)
      else $error("Ready driven while deselected.");
   ready_low_a: assert property ((sep && !cs_s && !done_reg) |=> !ack_out)
      else $error("Ready not low before completion.");
   ack_idle_a: assert property ((!sep && started_reg && !done_reg) |=> ack_out && ack_oe)
      else $error("Acknowledge low without completion.");
   index_use_a: assert property (reg_rd |-> reg_addr == $past(addr_s))
      else $error("Read index not taken from address pins.");

   sep_read_c:  cover property (sep && rd_start ##[1:4] host_data_oe);
   sep_write_c: cover property (sep && wr_commit ##1 reg_wr);
   addr_read_c: cover property (!sep && rd_start ##[1:4] !ack_out);
   addr_write_c: cover property (!sep && wr_commit ##[1:3] !ack_out);

endmodule : hrap_host_port

// file: inc/hrap_defs.svh
`ifndef HRAP_DEFS_SVH
`define HRAP_DEFS_SVH
// ==========================================================================
// Host register access port constants
// ==========================================================================
// Width of the host address bus (register index).
`define HRAP_ADDR_W 12
// Width of the host data bus.
`define HRAP_DATA_W 8
// Width of the bundle of pins that pass through the input synchroniser.
`define HRAP_SYNC_W 24
// Field positions inside the synchronised pin bundle.
`define HRAP_POS_CS     0
`define HRAP_POS_ASTB   1
`define HRAP_POS_WSD    2
`define HRAP_POS_RDRW   3
`define HRAP_POS_ADDR   4
`define HRAP_POS_DATA   16
// Cycles after reset release before the mode strap is trusted.
`define HRAP_START_CNT  2'h2
// Reset values of the pin drivers and the sync bundle.
`define HRAP_DATA_RST   8'h00
`define HRAP_ADDR_RST   12'h000
`define HRAP_SYNC_RST   24'h00000f
`define HRAP_ACK_RST    1'b1
`define HRAP_OE_RST     1'b0
`endif

// file: inc/hrap_pkg.sv
// ==========================================================================
// Host register access port types
// ==========================================================================
package hrap_pkg;
   // Strobe style chosen by the mode strap.
   typedef enum logic {HRAP_MODE_ADDR_STROBE, HRAP_MODE_SEP_STROBE} hrap_mode_type;
   // Access sequencer states.
   typedef enum logic [1:0] {HRAP_ST_IDLE, HRAP_ST_READ, HRAP_ST_DONE} hrap_state_type;
endpackage : hrap_pkg

// file: tb/hrap_host_model.sv
`timescale 1ns/1ps
`include "hrap_defs.svh"
// ==========================================================================
// Host processor model driving the parallel host port
// ==========================================================================
module hrap_host_model (
   input  wire logic                    clk_sys,                // System clock.
   input  wire logic                    sep_mode,               // High for separate strobes.
   input  wire logic [`HRAP_DATA_W-1:0] host_data_out,          // Device read data.
   input  wire logic                    host_data_oe,           // Device drives the bus.
   input  wire logic                    ack_out,                // Ready or acknowledge level.
   input  wire logic                    ack_oe,                 // Ready or acknowledge enable.
   output logic                         chip_select_n,          // Select, separate style.
   output logic                         address_latch_strobe_n, // Select, address style.
   output logic                         write_or_data_strobe_n, // Write or data strobe.
   output logic                         read_or_direction,      // Read strobe or direction.
   output logic      [`HRAP_ADDR_W-1:0] host_addr,              // Register index.
   output logic      [`HRAP_DATA_W-1:0] host_data_in            // Resolved data bus.
);
   logic [`HRAP_DATA_W-1:0] drv_data; // Write data placed by the host.
   logic                    drv_en;   // Host drives the bus.
   logic [`HRAP_DATA_W-1:0] last_bus; // Previous bus level.
   // A done level differs by style: ready high, or acknowledge low.
   wire done = ack_oe && (ack_out === sep_mode);
   // The bus has no pull, so a floating bus shows a pattern changing every cycle.
   assign host_data_in = host_data_oe ? host_data_out : (drv_en ? drv_data : ~last_bus);
   always @(posedge clk_sys) last_bus <= host_data_in;
   // Idle pins, and a known floating pattern so the bus never stays unknown.
   initial begin
      last_bus = 8'h00;
      chip_select_n = 1'b1;
      address_latch_strobe_n = 1'b1;
      write_or_data_strobe_n = 1'b1;
      read_or_direction = 1'b1;
      host_addr = 12'h000;
      drv_data = 8'h00;
      drv_en = 1'b0;
   end
   // One access; every pin changes only at falling edges; all but a write strobe stay until done.
   task automatic access(input logic rd, input logic [11:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic early, output logic ok);
      int n;
      ok = 1'b0;
      q = 8'h00;
      @(negedge clk_sys);
      host_addr = a;
      drv_data = d;
      drv_en = !rd;
      chip_select_n = !sep_mode;
      address_latch_strobe_n = sep_mode;
      read_or_direction = sep_mode ? !rd : rd;
      write_or_data_strobe_n = sep_mode ? rd : 1'b0;
      repeat (3) @(negedge clk_sys);
      early = ack_oe && (ack_out === !sep_mode);
      if (!rd) begin
         repeat (4) @(negedge clk_sys);
         write_or_data_strobe_n = 1'b1;
      end
      // Bounded wait: a missing answer is reported, never hung on.
      // The answer is looked at on the falling edge, where it has settled.
      for (n = 0; n < 40 && !ok; n++) begin
         @(negedge clk_sys);
         ok = done;
      end
      q = host_data_in;
      @(negedge clk_sys);
      write_or_data_strobe_n = 1'b1;
      if (sep_mode) read_or_direction = 1'b1;
      repeat (2) @(negedge clk_sys);
      chip_select_n = 1'b1;
      address_latch_strobe_n = 1'b1;
      drv_en = 1'b0;
      repeat (8) @(negedge clk_sys);
   endtask : access
endmodule : hrap_host_model

// file: tb/host_register_access_port_bench.sv
`timescale 1ns/1ps
`include "hrap_defs.svh"
// ==========================================================================
// Self-checking bench for the host port
// ==========================================================================
`define HRAP_TB_CHECK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
   miscompares++; $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module host_register_access_port_bench;
   logic clk_sys, reset_n, mode_strap, cs_n, astb_n, ws_n, rd_dir;
   logic [11:0] host_addr, reg_addr;
   logic [7:0]  host_data_in, host_data_out, reg_wdata, reg_rdata;
   logic        host_data_oe, ack_out, ack_oe, reg_wr, reg_rd;
   logic [7:0]  reg_file [0:4095]; // Register file behind the port.
   int          model [int];       // Reference contents written by the host.
   int          wr_count = 0;      // Write pulses seen.
   int          rd_count = 0;      // Read pulses seen.
   int          miscompares = 0;
   int          n_compared = 0;
   hrap_host_port DUT (.clk_sys(clk_sys), .reset_n(reset_n), .mode_strap(mode_strap),
      .chip_select_n(cs_n), .address_latch_strobe_n(astb_n), .write_or_data_strobe_n(ws_n),
      .read_or_direction(rd_dir), .host_addr(host_addr), .host_data_in(host_data_in),
      .host_data_out(host_data_out), .host_data_oe(host_data_oe), .ack_out(ack_out),
      .ack_oe(ack_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   hrap_host_model HOST (.clk_sys(clk_sys), .sep_mode(mode_strap),
      .host_data_out(host_data_out), .host_data_oe(host_data_oe), .ack_out(ack_out),
      .ack_oe(ack_oe), .chip_select_n(cs_n), .address_latch_strobe_n(astb_n),
      .write_or_data_strobe_n(ws_n), .read_or_direction(rd_dir), .host_addr(host_addr),
      .host_data_in(host_data_in));
   // The register file answers combinationally from the index, as agreed.
   assign reg_rdata = reg_file[reg_addr];
   // Register file and pulse counters; each access must give exactly one pulse.
   always @(posedge clk_sys) begin
      if (reg_wr === 1'b1) begin
         reg_file[reg_addr] <= reg_wdata;
         wr_count <= wr_count + 1;
      end
      if (reg_rd === 1'b1) begin
         rd_count <= rd_count + 1;
      end
   end
   // System clock, 200 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   function automatic logic [7:0] exp_of(input logic [11:0] a);
      return model.exists(int'(a)) ? 8'(model[int'(a)]) : 8'h00;
   endfunction : exp_of
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   // Reset with the chosen strap, then mixed writes and reads on a small address pool.
   task automatic run_mode(input logic sep);
      logic [11:0] a;
      logic [7:0]  d, q;
      logic        early, ok;
      int          i, wb, rb, k;
      mode_strap = sep;
      reset_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      reset_n = 1'b1;
      repeat (8) @(negedge clk_sys);
      for (i = 0; i < 16; i++) begin
         k = $urandom_range(0, 4);
         a = (k == 4) ? 12'hfff : 12'(k);
         d = 8'($urandom);
         wb = wr_count;
         rb = rd_count;
         HOST.access(i[0], a, d, q, early, ok);
         `HRAP_TB_CHECK("done seen", 1'b1, ok)
         if (ok !== 1'b1) results();
         `HRAP_TB_CHECK("early ack", 1'b1, early)
         if (i[0]) begin
            `HRAP_TB_CHECK("read data", exp_of(a), q)
            `HRAP_TB_CHECK("read count", rb + 1, rd_count)
            `HRAP_TB_CHECK("no write on read", wb, wr_count)
         end else begin
            model[int'(a)] = d;
            `HRAP_TB_CHECK("write count", wb + 1, wr_count)
            `HRAP_TB_CHECK("no read on write", rb, rd_count)
         end
         `HRAP_TB_CHECK("bus released", 1'b0, host_data_oe)
         `HRAP_TB_CHECK("ack idle", !sep, sep ? ack_oe : ack_out)
         $display("test mode %0d access %0d addr %h ended", sep, i, a);
      end
   endtask : run_mode
   initial begin
      for (int j = 0; j < 4096; j++) reg_file[j] = 8'h00;
      reset_n = 1'b0;
      mode_strap = 1'b1;
      void'($urandom(32'h4a62733c));
      run_mode(1'b1);
      run_mode(1'b0);
      results();
   end
endmodule : host_register_access_port_bench
